// *** hw/rhph_defs.vh ***
// Constants for the radio host power handshake block.
//
// Function
// - Asserted host wake input brings the radio out of sleep or keeps it awake.
// - Deasserted host wake input allows sleep only once sleep criteria hold.
// - Software selects active level of both wake signals, high or low.
// - Radio asserts its host wake output when it needs host attention.
// - Reference clock request goes high when radio or WLAN core needs it.
// - Wake handshake works only in UART transport mode and when enabled.
// - Power actions come from software registers and from baseband packet logic.
// - Separate power-downs drive transmit path, receive path, PLL and amplifier.
// - Packet logic turns the front end on and off within each packet.
// - Sniff, hold and park run on slow oscillator and wake after interval.
// - During shutdown every pin except the bus slave outputs keeps the state it had on entry.
// - Leaving shutdown behaves like cold power-up, keeping no prior state.
// - Broadcast receiver subsystem is either fully on or fully off.
// - Command controller drives standby, connection, page, scans, inquiry and sniff.
// - Test transmit sends carrier, or modulated 8-bit pattern or PRBS-9 payload.
// - Constant receive test routes demodulated bits to an output pin.
`ifndef RHPH_DEFS_VH
`define RHPH_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define RHPH_OFS_CTRL    5'h00
`define RHPH_OFS_PWRDN   5'h04
`define RHPH_OFS_LINK    5'h08
`define RHPH_OFS_TEST    5'h0C
`define RHPH_OFS_SLEEP   5'h10
`define RHPH_OFS_STATUS  5'h14

// ****************************************************************
// Control register fields.
// ****************************************************************
`define RHPH_CTRL_HS_EN    0
`define RHPH_CTRL_UART     1
`define RHPH_CTRL_DEV_POL  2
`define RHPH_CTRL_HOST_POL 3
`define RHPH_CTRL_SLEEP_EN 4
`define RHPH_CTRL_FM_ON    5
`define RHPH_CTRL_SHUTDN   6
`define RHPH_CTRL_RESET    7'h00
`define RHPH_SLEEP_RESET   16'h0020
`define RHPH_PAT_RESET     8'hA5

// ****************************************************************
// Link control states, also used as command codes.
// ****************************************************************
`define RHPH_LC_STANDBY  4'h0
`define RHPH_LC_PAGE     4'h1
`define RHPH_LC_PSCAN    4'h2
`define RHPH_LC_INQ      4'h3
`define RHPH_LC_ISCAN    4'h4
`define RHPH_LC_CONN     4'h5
`define RHPH_LC_SNIFF    4'h6
`define RHPH_LC_HOLD     4'h7
`define RHPH_LC_PARK     4'h8

// ****************************************************************
// Test modes.
// ****************************************************************
`define RHPH_TM_OFF      2'h0
`define RHPH_TM_CARRIER  2'h1
`define RHPH_TM_TX_PAT   2'h2
`define RHPH_TM_RX_BER   2'h3
`define RHPH_PRBS_SEED   9'h1FF

// ****************************************************************
// Timing.
// ****************************************************************
`define RHPH_CLK_MHZ       20
`define RHPH_TEST_BIT_NS   1000
`define RHPH_AWAKE_MIN_NS  10000
`define RHPH_TEST_BIT_CYC  ((`RHPH_TEST_BIT_NS * `RHPH_CLK_MHZ) / 1000)
`define RHPH_AWAKE_MIN_CYC ((`RHPH_AWAKE_MIN_NS * `RHPH_CLK_MHZ) / 1000)

`endif

// *** hw/rhph_sync2.v ***
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module rhph_sync2 #(
   parameter W = 1
) (
   // Clock and reset.
   input  wire         clock_i,
   input  wire         rst_n_i,
   // Asynchronous input and synchronised output.
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);
   reg [W-1:0] meta;

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         meta <= {W{1'b0}};
         q_o  <= {W{1'b0}};
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

// *** hw/rhph_top.v ***
// Power handshake, sleep, link control and test sequencing for the radio core.
`timescale 1ns/1ps
`default_nettype none
`include "rhph_defs.vh"
module rhph_top #(
   parameter TEST_BIT_CYC  = `RHPH_TEST_BIT_CYC,
   parameter AWAKE_MIN_CYC = `RHPH_AWAKE_MIN_CYC
) (
   // Clock and reset.
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Avalon-MM slave.
   input  wire [4:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   // Host handshake pins.
   input  wire        host_to_radio_wake_i,
   output reg         radio_to_host_wake_o,
   output reg         radio_ref_clock_request_pin_o,
   output reg         wlan_ref_clock_request_pin_o,
   // Slow oscillator pin.
   input  wire        low_power_oscillator_input_i,
   output reg         lpo_clock_select_o,
   // Baseband core and WLAN core.
   input  wire        pkt_tx_active_i,
   input  wire        pkt_rx_active_i,
   input  wire        host_traffic_pending_i,
   input  wire        wlan_clock_need_i,
   input  wire        rx_demod_bit_i,
   // Front end power-downs.
   output reg         tx_pd_o,
   output reg         rx_pd_o,
   output reg         pll_pd_o,
   output reg         pa_pd_o,
   // Test, broadcast receiver and shutdown.
   output reg         test_tx_bit_o,
   output reg         test_tx_mod_en_o,
   output reg         test_io_o,
   output reg         fm_power_on_o,
   output reg         shutdown_o
);
   // Power manager states.
   localparam PM_AWAKE = 2'h0;
   localparam PM_SLEEP = 2'h1;
   localparam PM_SHUT  = 2'h2;

   // ****************************************************************
   // Pin synchronisers.
   // ****************************************************************
   wire dev_sync;
   wire lpo_sync;
   reg  lpo_dly;

   rhph_sync2 #(.W(1)) u_dev_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (host_to_radio_wake_i),
      .q_o     (dev_sync)
   );

   rhph_sync2 #(.W(1)) u_lpo_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (low_power_oscillator_input_i),
      .q_o     (lpo_sync)
   );

   // ****************************************************************
   // Registers and state.
   // ****************************************************************
   reg  [6:0]  ctrl;
   reg  [3:0]  pwrdn;
   reg  [3:0]  lc_state;
   reg         lc_err;
   reg  [1:0]  test_mode;
   reg         test_prbs;
   reg  [7:0]  test_pat;
   reg  [15:0] sleep_ivl;
   reg  [1:0]  pm_state;
   reg  [15:0] lpo_cnt;
   reg  [15:0] awake_cnt;
   reg         ack;
   reg  [31:0] rd_mux;
   reg         lc_legal;

   wire acc      = avs_read_i | avs_write_i;
   wire wr_fire  = avs_write_i & ack;
   wire running  = (pm_state != PM_SHUT);
   wire awake    = (pm_state == PM_AWAKE);
   wire lpo_tick = lpo_sync & ~lpo_dly;
   wire [3:0] lc_cmd = avs_writedata_i[3:0];

   wire hs_on        = ctrl[`RHPH_CTRL_HS_EN] & ctrl[`RHPH_CTRL_UART];
   wire dev_wake_act = hs_on & (dev_sync ^ ctrl[`RHPH_CTRL_DEV_POL]);
   wire host_wk_act  = hs_on & host_traffic_pending_i;
   wire lp_conn      = (lc_state == `RHPH_LC_SNIFF) | (lc_state == `RHPH_LC_HOLD) |
                       (lc_state == `RHPH_LC_PARK);
   // The radio asks for the reference clock while awake.
   wire ref_req      = awake | wlan_clock_need_i;

   wire tx_need = (awake & pkt_tx_active_i) |
                  (test_mode == `RHPH_TM_CARRIER) | (test_mode == `RHPH_TM_TX_PAT);
   wire rx_need = (awake & pkt_rx_active_i) | (test_mode == `RHPH_TM_RX_BER);

   // Sleep needs quiet wake sources and the awake minimum spent.
   wire sleep_ok = ~dev_wake_act & ~host_traffic_pending_i &
                   ~pkt_tx_active_i & ~pkt_rx_active_i &
                   (test_mode == `RHPH_TM_OFF) & (awake_cnt == 16'h0000) &
                   (lp_conn | (ctrl[`RHPH_CTRL_SLEEP_EN] & (lc_state == `RHPH_LC_STANDBY)));

   // ****************************************************************
   // Bus slave: one wait cycle, then the answer.
   // ****************************************************************
   // A request is answered in the cycle after it rises.
   assign avs_waitrequest_o = acc & ~ack;

   always @* begin
      rd_mux = 32'h0000_0000;
      case (avs_address_i & 5'h1C)
         `RHPH_OFS_CTRL: begin
            rd_mux[6:0] = ctrl;
         end
         `RHPH_OFS_PWRDN: begin
            rd_mux[3:0] = pwrdn;
         end
         `RHPH_OFS_LINK: begin
            rd_mux[4:0] = {lc_err, lc_state};
         end
         `RHPH_OFS_TEST: begin
            rd_mux[15:0] = {test_pat, 5'h00, test_prbs, test_mode};
         end
         `RHPH_OFS_SLEEP: begin
            rd_mux[15:0] = sleep_ivl;
         end
         `RHPH_OFS_STATUS: begin
            rd_mux[13:0] = {pa_pd_o, pll_pd_o, rx_pd_o, tx_pd_o, lc_err, lc_state,
                            ref_req, host_wk_act, dev_wake_act, pm_state};
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // An illegal command keeps the state and sets the error flag.
   always @* begin
      case (lc_cmd)
         `RHPH_LC_STANDBY: lc_legal = 1'b1;
         `RHPH_LC_PAGE,
         `RHPH_LC_PSCAN,
         `RHPH_LC_INQ,
         `RHPH_LC_ISCAN:   lc_legal = (lc_state == `RHPH_LC_STANDBY);
         `RHPH_LC_CONN:    lc_legal = (lc_state == `RHPH_LC_PAGE) |
                                      (lc_state == `RHPH_LC_PSCAN) | lp_conn;
         `RHPH_LC_SNIFF,
         `RHPH_LC_HOLD,
         `RHPH_LC_PARK:    lc_legal = (lc_state == `RHPH_LC_CONN);
         default:          lc_legal = 1'b0;
      endcase
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         ack            <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         ack <= acc & ~ack;
         if (avs_read_i & ~ack) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   // ****************************************************************
   // Register writes and link control commands.
   // ****************************************************************
   wire wr_sel_ctrl  = wr_fire & ((avs_address_i & 5'h1C) == `RHPH_OFS_CTRL);
   wire wr_sel_pwrdn = wr_fire & ((avs_address_i & 5'h1C) == `RHPH_OFS_PWRDN);
   wire wr_sel_link  = wr_fire & ((avs_address_i & 5'h1C) == `RHPH_OFS_LINK);
   wire wr_sel_test  = wr_fire & ((avs_address_i & 5'h1C) == `RHPH_OFS_TEST);
   wire wr_sel_sleep = wr_fire & ((avs_address_i & 5'h1C) == `RHPH_OFS_SLEEP);

   // Registers freeze in shutdown and only reset clears them.
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl      <= `RHPH_CTRL_RESET;
         pwrdn     <= 4'h0;
         lc_state  <= `RHPH_LC_STANDBY;
         lc_err    <= 1'b0;
         test_mode <= `RHPH_TM_OFF;
         test_prbs <= 1'b0;
         test_pat  <= `RHPH_PAT_RESET;
         sleep_ivl <= `RHPH_SLEEP_RESET;
      end else if (running) begin
         if (wr_sel_ctrl) begin
            ctrl <= avs_writedata_i[6:0];
         end
         if (wr_sel_pwrdn) begin
            pwrdn <= avs_writedata_i[3:0];
         end

         if (wr_sel_link) begin
            lc_err <= ~lc_legal;
            if (lc_legal) begin
               lc_state <= lc_cmd;
            end
         end
         if (wr_sel_test) begin
            test_mode <= avs_writedata_i[1:0];
            test_prbs <= avs_writedata_i[2];
            test_pat  <= avs_writedata_i[15:8];
         end
         if (wr_sel_sleep) begin
            sleep_ivl <= avs_writedata_i[15:0];
         end
      end
   end

   // ****************************************************************
   // Sleep sequencer.
   // ****************************************************************
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         pm_state  <= PM_AWAKE;
         lpo_cnt   <= 16'h0000;
         awake_cnt <= AWAKE_MIN_CYC[15:0];
         lpo_dly   <= 1'b0;
      end else begin
         lpo_dly <= lpo_sync;
         case (pm_state)
            PM_AWAKE: begin
               if (awake_cnt != 16'h0000) begin
                  awake_cnt <= awake_cnt - 16'h0001;
               end
               if (ctrl[`RHPH_CTRL_SHUTDN]) begin
                  pm_state <= PM_SHUT;
               end else if (sleep_ok) begin
                  pm_state <= PM_SLEEP;
                  lpo_cnt  <= sleep_ivl;
               end
            end

            PM_SLEEP: begin
               // A host request wins over the wake timer.
               if (dev_wake_act | host_traffic_pending_i) begin
                  pm_state  <= PM_AWAKE;
                  awake_cnt <= AWAKE_MIN_CYC[15:0];
               end else if (lpo_tick) begin
                  if (lpo_cnt <= 16'h0001) begin
                     pm_state  <= PM_AWAKE;
                     awake_cnt <= AWAKE_MIN_CYC[15:0];
                  end else begin
                     lpo_cnt <= lpo_cnt - 16'h0001;
                  end
               end
            end

            PM_SHUT: begin
               // Only reset leaves shutdown.
               pm_state <= PM_SHUT;
            end

            default: begin
               pm_state <= PM_AWAKE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Pin outputs, frozen while shut down.
   // ****************************************************************
   // Frozen pins keep the block from loading the host in shutdown.
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         radio_to_host_wake_o          <= 1'b0;
         radio_ref_clock_request_pin_o <= 1'b0;
         wlan_ref_clock_request_pin_o  <= 1'b0;
         lpo_clock_select_o            <= 1'b0;
         tx_pd_o                       <= 1'b1;
         rx_pd_o                       <= 1'b1;
         pll_pd_o                      <= 1'b1;
         pa_pd_o                       <= 1'b1;
         fm_power_on_o                 <= 1'b0;
         shutdown_o                    <= 1'b0;
      end else if (running) begin
         radio_to_host_wake_o          <= host_wk_act ^ ctrl[`RHPH_CTRL_HOST_POL];
         radio_ref_clock_request_pin_o <= ref_req;
         wlan_ref_clock_request_pin_o  <= ref_req;
         lpo_clock_select_o            <= (pm_state == PM_SLEEP);
         tx_pd_o                       <= ~tx_need | pwrdn[0];
         rx_pd_o                       <= ~rx_need | pwrdn[1];
         pll_pd_o                      <= ~(tx_need | rx_need) | pwrdn[2];
         pa_pd_o                       <= ~tx_need | pwrdn[3];
         fm_power_on_o                 <= ctrl[`RHPH_CTRL_FM_ON];
         shutdown_o                    <= ctrl[`RHPH_CTRL_SHUTDN] & awake;
      end
   end

   // ****************************************************************
   // Test transmit and receive.
   // ****************************************************************
   // A test register write restarts the bit timer and both generators.
   reg [15:0] bit_cnt;
   reg [8:0]  prbs;
   reg [7:0]  pat_sh;
   wire       bit_en = (bit_cnt == 16'h0000);

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         bit_cnt          <= 16'h0000;
         prbs             <= `RHPH_PRBS_SEED;
         pat_sh           <= `RHPH_PAT_RESET;
         test_tx_bit_o    <= 1'b0;
         test_tx_mod_en_o <= 1'b0;
         test_io_o        <= 1'b0;
      end else if (running) begin
         if (wr_sel_test) begin
            bit_cnt <= 16'h0000;
            prbs    <= `RHPH_PRBS_SEED;
            pat_sh  <= avs_writedata_i[15:8];
         end else if (bit_en) begin
            bit_cnt <= TEST_BIT_CYC[15:0] - 16'h0001;
            prbs    <= {prbs[7:0], prbs[8] ^ prbs[4]};
            pat_sh  <= {pat_sh[6:0], pat_sh[7]};
         end else begin
            bit_cnt <= bit_cnt - 16'h0001;
         end

         test_tx_mod_en_o <= (test_mode == `RHPH_TM_TX_PAT);
         if (test_mode == `RHPH_TM_TX_PAT) begin
            test_tx_bit_o <= test_prbs ? prbs[8] : pat_sh[7];
         end else begin
            test_tx_bit_o <= 1'b0;
         end

         test_io_o <= (test_mode == `RHPH_TM_RX_BER) & rx_demod_bit_i;
      end
   end
endmodule
`default_nettype wire

// *** testbench/rhph_chk.sv ***
// Checker of pin and bus timing for the radio host power handshake block.
`timescale 1ns/1ps
`default_nettype none
module rhph_chk #(
   parameter TEST_BIT_CYC  = 20,
   parameter AWAKE_MIN_CYC = 200
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Bus and core inputs.
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic host_traffic_pending_i,
   input wire logic pkt_tx_active_i,
   input wire logic pkt_rx_active_i,
   input wire logic wlan_clock_need_i,
   input wire logic rx_demod_bit_i,
   // Observed outputs.
   input wire logic avs_waitrequest_o,
   input wire logic radio_to_host_wake_o,
   input wire logic radio_ref_clock_request_pin_o,
   input wire logic wlan_ref_clock_request_pin_o,
   input wire logic lpo_clock_select_o,
   input wire logic tx_pd_o,
   input wire logic rx_pd_o,
   input wire logic pa_pd_o,
   input wire logic test_io_o,
   input wire logic fm_power_on_o,
   input wire logic shutdown_o
);
   wire logic [7:0] pins = {radio_to_host_wake_o, radio_ref_clock_request_pin_o, lpo_clock_select_o,
                            tx_pd_o, rx_pd_o, pa_pd_o, test_io_o, fm_power_on_o};
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   wait_one_a: assert property (
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("Bus wait not one cycle.");
   ref_pair_a: assert property (radio_ref_clock_request_pin_o == wlan_ref_clock_request_pin_o)
      else $error("Request pins differ.");
   wlan_req_a: assert property (
      wlan_clock_need_i && !shutdown_o |=> wlan_ref_clock_request_pin_o || shutdown_o)
      else $error("Clock need not requested.");
   ref_awake_a: assert property (
      !lpo_clock_select_o && $past(rst_n_i) && !$past(lpo_clock_select_o) |-> radio_ref_clock_request_pin_o)
      else $error("Awake without request.");
   sleep_off_a: assert property (lpo_clock_select_o |-> tx_pd_o && rx_pd_o && pa_pd_o)
      else $error("Front end on in sleep.");
   sleep_entry_a: assert property (
      $rose(lpo_clock_select_o) |-> !$past(host_traffic_pending_i, 2) && !$past(pkt_tx_active_i, 2)
      && !$past(pkt_rx_active_i, 2))
      else $error("Sleep entered while busy.");
   pend_wake_a: assert property (
      lpo_clock_select_o && host_traffic_pending_i |-> ##[1:4] (!lpo_clock_select_o || !host_traffic_pending_i))
      else $error("Pending traffic did not wake.");
   ber_copy_a: assert property (test_io_o && !shutdown_o |-> $past(rx_demod_bit_i))
      else $error("Test pin not from receiver bit.");
   cold_start_a: assert property (
      $rose(rst_n_i) |-> tx_pd_o && rx_pd_o && pa_pd_o && !shutdown_o && !fm_power_on_o && !radio_to_host_wake_o)
      else $error("Outputs not cold after reset.");
   shut_hold_a: assert property ($past(shutdown_o) |-> shutdown_o && $stable(pins))
      else $error("Pins moved in shutdown.");
endmodule
bind rhph_top rhph_chk #(.TEST_BIT_CYC(TEST_BIT_CYC), .AWAKE_MIN_CYC(AWAKE_MIN_CYC)) chk_i (
   .clock_i, .rst_n_i, .avs_read_i, .avs_write_i, .host_traffic_pending_i, .pkt_tx_active_i,
   .pkt_rx_active_i, .wlan_clock_need_i, .rx_demod_bit_i, .avs_waitrequest_o, .radio_to_host_wake_o,
   .radio_ref_clock_request_pin_o, .wlan_ref_clock_request_pin_o, .lpo_clock_select_o, .tx_pd_o,
   .rx_pd_o, .pa_pd_o, .test_io_o, .fm_power_on_o, .shutdown_o);
`default_nettype wire

// *** testbench/rhph_host_model.sv ***
// Host processor model on the wake lines.
`timescale 1ns/1ps
`default_nettype none
module rhph_host_model (
   // Clock and host controls.
   input  wire logic clock_i,
   input  wire logic wake_req_i,
   input  wire logic dev_pol_i,
   input  wire logic host_pol_i,
   // Wake pins and host state.
   input  wire logic radio_to_host_wake_i,
   output var  logic host_to_radio_wake_o,
   output var  logic host_awake_o
);
   initial host_to_radio_wake_o = 1'b0;
   initial host_awake_o = 1'b1;
   always @(posedge clock_i) begin
      host_to_radio_wake_o <= wake_req_i ^ dev_pol_i;
      host_awake_o         <= wake_req_i | (radio_to_host_wake_i ^ host_pol_i);
   end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the radio host power handshake block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int TB = 4;
   logic clock_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
   logic [4:0] avs_address_i = 5'h00;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, d, s;
   logic host_to_radio_wake_i, radio_to_host_wake_o, radio_ref_clock_request_pin_o, wlan_ref_clock_request_pin_o;
   logic low_power_oscillator_input_i = 1'b0, lpo_clock_select_o, pkt_tx_active_i = 1'b0, pkt_rx_active_i = 1'b0;
   logic host_traffic_pending_i = 1'b0, wlan_clock_need_i = 1'b0, rx_demod_bit_i = 1'b0;
   logic tx_pd_o, rx_pd_o, pll_pd_o, pa_pd_o, test_tx_bit_o, test_tx_mod_en_o, test_io_o, fm_power_on_o, shutdown_o;
   logic wake_req = 1'b0, dev_pol = 1'b0, host_awake;
   logic [8:0] lt [17] = '{9'h0B0, 9'h021, 9'h0A5, 9'h0C6, 9'h0A5, 9'h0E7, 9'h0A5, 9'h108, 9'h000,
                           9'h042, 9'h032, 9'h000, 9'h063, 9'h000, 9'h084, 9'h0D4, 9'h000};
   logic [7:0] hc [5] = '{8'h03, 8'h0B, 8'h01, 8'h09, 8'h02};
   int n_fail = 0, comparisons = 0, i;
   rhph_top #(.TEST_BIT_CYC(TB), .AWAKE_MIN_CYC(4)) dut (.clock_i, .rst_n_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .host_to_radio_wake_i,
      .radio_to_host_wake_o, .radio_ref_clock_request_pin_o, .wlan_ref_clock_request_pin_o,
      .low_power_oscillator_input_i, .lpo_clock_select_o, .pkt_tx_active_i, .pkt_rx_active_i,
      .host_traffic_pending_i, .wlan_clock_need_i, .rx_demod_bit_i, .tx_pd_o, .rx_pd_o, .pll_pd_o, .pa_pd_o,
      .test_tx_bit_o, .test_tx_mod_en_o, .test_io_o, .fm_power_on_o, .shutdown_o);
   rhph_host_model host (.clock_i, .wake_req_i(wake_req), .dev_pol_i(dev_pol), .host_pol_i(1'b0),
      .radio_to_host_wake_i(radio_to_host_wake_o), .host_to_radio_wake_o(host_to_radio_wake_i),
      .host_awake_o(host_awake));
   initial forever #25 clock_i = ~clock_i;
   initial forever begin
      repeat (8) @(posedge clock_i);
      low_power_oscillator_input_i <= ~low_power_oscillator_input_i;
   end
   // ****************************************************************
   // Bus access, comparison and closing tasks.
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic rw, input logic [4:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_read_i <= !rw;
      avs_write_i <= rw;
      do begin
         @(posedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      d = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      chk("waitrequest", 32'h0, 32'(avs_waitrequest_o));
      @(posedge clock_i);
   endtask
   task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, d);
   endtask
   task automatic wt(input string nm, ref logic sg, input logic v, input int lim);
      int n;
      n = 0;
      while (sg !== v && n < lim) begin
         @(posedge clock_i);
         n++;
      end
      chk(nm, 32'(v), 32'(sg));
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock_i);
      n_fail++;
      complete_run();
   end
   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rdc("ctrl", 5'h00, 32'h0);
      rdc("sleep", 5'h10, 32'h20);
      rdc("test", 5'h0C, 32'hA500);
      bus(1'b1, 5'h18, 32'hFFFF);
      rdc("unmapped", 5'h18, 32'h0);
      for (i = 0; i < 17; i++) begin
         bus(1'b1, 5'h08, {28'h0, lt[i][8:5]});
         rdc("link", 5'h08, {27'h0, lt[i][4:0]});
      end
      host_traffic_pending_i <= 1'b1;
      wt("awake", lpo_clock_select_o, 1'b0, 10);
      host_traffic_pending_i <= 1'b0;
      pkt_tx_active_i <= 1'b1;
      pkt_rx_active_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk("rf on", 32'h0, 32'({tx_pd_o, rx_pd_o, pll_pd_o, pa_pd_o}));
      bus(1'b1, 5'h04, 32'h2);
      @(posedge clock_i);
      chk("rf forced", 32'h4, 32'({tx_pd_o, rx_pd_o, pll_pd_o, pa_pd_o}));
      bus(1'b1, 5'h04, 32'h0);
      pkt_tx_active_i <= 1'b0;
      pkt_rx_active_i <= 1'b0;
      bus(1'b1, 5'h0C, 32'h8002);
      wt("mod en", test_tx_mod_en_o, 1'b1, 5);
      for (i = 0; i < 32; i++) begin
         repeat (TB) @(posedge clock_i);
         s[i] = test_tx_bit_o;
      end
      chk("pattern", {s[7:0], 24'h1}, {s[15:8], 24'($countones(s[7:0]))});
      bus(1'b1, 5'h0C, 32'h8006);
      for (i = 0; i < 32; i++) begin
         repeat (TB) @(posedge clock_i);
         s[i] = test_tx_bit_o;
      end
      chk("prbs", 32'h1, 32'(s != 32'h0 && s != 32'hFFFFFFFF));
      bus(1'b1, 5'h0C, 32'h1);
      @(posedge clock_i);
      chk("carrier", 32'h0, 32'({test_tx_mod_en_o, tx_pd_o}));
      bus(1'b1, 5'h0C, 32'h3);
      for (i = 1; i >= 0; i--) begin
         rx_demod_bit_i <= i[0];
         repeat (3) @(posedge clock_i);
         chk("ber bit", 32'(i), 32'({rx_pd_o, test_io_o}));
      end
      bus(1'b1, 5'h0C, 32'h0);
      host_traffic_pending_i <= 1'b1;
      for (i = 0; i < 5; i++) begin
         bus(1'b1, 5'h00, {24'h0, hc[i]});
         repeat (3) @(posedge clock_i);
         chk("host wake", 32'((hc[i][1:0] == 2'h3) ^ hc[i][3]), 32'(radio_to_host_wake_o));
      end
      bus(1'b1, 5'h00, 32'h3);
      repeat (3) @(posedge clock_i);
      chk("host awake", 32'h1, 32'(host_awake));
      host_traffic_pending_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk("host release", 32'h0, 32'({radio_to_host_wake_o, host_awake}));
      bus(1'b1, 5'h10, 32'h3);
      bus(1'b1, 5'h00, 32'h10);
      wt("asleep", lpo_clock_select_o, 1'b1, 20);
      chk("sleep pins", 32'hE, 32'({tx_pd_o, rx_pd_o, pa_pd_o, radio_ref_clock_request_pin_o}));
      wlan_clock_need_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk("ref req", 32'h3, 32'({radio_ref_clock_request_pin_o, wlan_ref_clock_request_pin_o}));
      wlan_clock_need_i <= 1'b0;
      wt("timer wake", lpo_clock_select_o, 1'b0, 150);
      bus(1'b1, 5'h10, 32'h100);
      for (i = 0; i < 2; i++) begin
         dev_pol <= i[0];
         bus(1'b1, 5'h00, {28'h1, 1'b0, i[0], 2'h3});
         repeat (8) @(posedge clock_i);
         wt("asleep", lpo_clock_select_o, 1'b1, 20);
         wake_req <= 1'b1;
         wt("dev wake", lpo_clock_select_o, 1'b0, 8);
         repeat (60) @(posedge clock_i);
         chk("held awake", 32'h0, 32'(lpo_clock_select_o));
         wake_req <= 1'b0;
         wt("sleep again", lpo_clock_select_o, 1'b1, 20);
      end
      bus(1'b1, 5'h00, 32'h20);
      host_traffic_pending_i <= 1'b1;
      wt("awake", lpo_clock_select_o, 1'b0, 10);
      host_traffic_pending_i <= 1'b0;
      chk("fm on", 32'h1, 32'(fm_power_on_o));
      bus(1'b1, 5'h00, 32'h60);
      wt("shut", shutdown_o, 1'b1, 5);
      bus(1'b1, 5'h00, 32'h0);
      pkt_tx_active_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk("frozen", 32'h3, 32'({fm_power_on_o, tx_pd_o}));
      pkt_tx_active_i <= 1'b0;
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rdc("ctrl cold", 5'h00, 32'h0);
      chk("cold pins", 32'h0, 32'({fm_power_on_o, shutdown_o}));
      rdc("status", 5'h14, 32'h3C10);
      complete_run();
   end
endmodule
`default_nettype wire
